// ### include/sar_ctl_consts.vh
// Constants for the converter control block: register byte offsets,
// field positions, reset values and phase lengths.
// Assumes the includer works on a 50 ns bus clock.
`ifndef SAR_CTL_CONSTS_VH
`define SAR_CTL_CONSTS_VH

`define OFF_STATUS_CONTROL_ONE 8'h00
`define OFF_STATUS_CONTROL_TWO 8'h04
`define OFF_RESULT_HIGH 8'h08
`define OFF_RESULT_LOW 8'h0C
`define OFF_COMPARE_VALUE_HIGH 8'h10
`define OFF_COMPARE_VALUE_LOW 8'h14
`define OFF_CONFIG_REG 8'h18
`define OFF_PIN_DISABLE_ONE 8'h1C
`define OFF_PIN_DISABLE_TWO 8'h20
`define OFF_PIN_DISABLE_THREE 8'h24

`define SC1_DONE_BIT 7
`define SC1_IRQ_EN_BIT 6
`define SC1_CONT_BIT 5
`define SC2_ACTIVE_BIT 7
`define SC2_HWTRG_BIT 6
`define SC2_CMP_EN_BIT 5
`define SC2_CMP_GT_BIT 4
`define CFG_LOWPWR_BIT 7
`define CFG_LSMP_BIT 4

`define CHANNEL_OFF 5'h1F
`define SC1_RESET 8'h1F
`define MODE_8BIT 2'h0
`define MODE_10BIT 2'h2
`define SRC_BUS 2'h0
`define SRC_BUS_HALF 2'h1
`define SRC_ALT 2'h2
`define SRC_ASYNC 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_PERIOD_NS 50
`define ASYNC_STARTUP_NS 5000
`define SETUP_CONVERSION_CLOCK 3
`define SAMPLE_SHORT_CONVERSION_CLOCK 6
`define SAMPLE_LONG_CONVERSION_CLOCK 26
`define FINISH_CONVERSION_CLOCK 2

`endif

// ### verification/sar_analog_model.sv
// Far side of the converter: a sampled channel and its comparator.
// Assumes the trial code spans the full 11-bit raw range.
`timescale 1ns/100ps
`default_nettype none
module sar_analog_model (
	input wire logic clk,
	input wire logic sample_r,
	input wire logic [10:0] dac_code_r,
	input wire logic [10:0] level,
	output logic comparator_in
);
	logic [10:0] held_r = 11'h000;
	// Held value is frozen once sampling ends, as the real switch isolates
	always @(posedge clk) begin
		if (sample_r) begin
			held_r <= level;
		end
	end
	assign comparator_in = held_r >= dac_code_r;
endmodule
`default_nettype wire

// ### verification/sar_conversion_control_chk.sv
// Bus, pin and reset checks for the converter control block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module sar_conversion_control_chk #(parameter PINS = 24) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [PINS-1:0] port_read_r,
	input wire logic [PINS-1:0] pin_analog_r,
	input wire logic sample_r,
	input wire logic [4:0] channel_r,
	input wire logic async_osc_enable_r,
	input wire logic conv_irq_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_ar;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	property p_rd_ans;
		s_ar |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_wr_ans;
		s_wr |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	property p_wr_busy;
		s_wr |=> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("ready while busy");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("response dropped");
	property p_rdata;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 &&
			(s_axi_rresp != 2'h2 || s_axi_rdata == 32'h00000000);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data upper bits");
	property p_pin;
		$stable(pin_analog_r) |=> (pin_analog_r & port_read_r) == '0;
	endproperty
	a_pin: assert property (p_pin) else $error("disabled pin read");
	property p_idle_off;
		channel_r == 5'h1F |-> !sample_r;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("sampling off");
	property p_rst;
		@(posedge clk) disable iff (1'b0) sys_rst |=> channel_r == 5'h1F &&
			!async_osc_enable_r && !conv_irq_r && !s_axi_bvalid && !sample_r;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind sar_conversion_control sar_conversion_control_chk #(.PINS(PINS)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
	.port_read_r(port_read_r), .pin_analog_r(pin_analog_r),
	.sample_r(sample_r), .channel_r(channel_r),
	.async_osc_enable_r(async_osc_enable_r), .conv_irq_r(conv_irq_r));
`default_nettype wire

// ### verification/sar_conversion_control_tb.sv
// Testbench for the converter control block: register tasks on the bus,
// then source, trigger, abort, compare and interlock sequences.
// Assumes a 20 MHz bus clock and the analog model on the far side.
`timescale 1ns/100ps
`default_nettype none
`include "sar_ctl_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch at %0t got %h exp %h", $time, g, e); end end
module sar_conversion_control_tb;
	logic clk = 0, sys_rst = 1, alt_clk = 0, async_clk = 0, hw_trig = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, cmp, stop = 0;
	logic osc_en, smp, lowp, irq, ta, tw;
	logic [1:0] bresp, rresp, resp;
	logic [23:0] pins = 0, port_read, pin_analog;
	logic [4:0] chan;
	logic [10:0] code, level = 11'h2A4;
	logic [7:0] cfgs[5] = '{8'hE8, 8'h49, 8'h0A, 8'h2B, 8'h78};
	// Unrelated source clocks get one extra period of phase margin
	int lims[5] = '{189, 190, 202, 255, 349};
	int bad_count = 0, num_checks = 0, cyc = 0, n;
	always #25 clk = ~clk;
	always #200.7 alt_clk = ~alt_clk;
	always #125.3 async_clk = ~async_clk;
	sar_conversion_control #(.STARTUP_CYC(4)) u_sar_conversion_control (
		.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.alternate_clock(alt_clk), .internal_async_clock(async_clk),
		.hw_trigger_input(hw_trig), .comparator_in(cmp), .stop_mode(stop),
		.port_pin_in(pins), .port_read_r(port_read),
		.pin_analog_r(pin_analog), .async_osc_enable_r(osc_en),
		.sample_r(smp), .channel_r(chan), .dac_code_r(code),
		.low_power_r(lowp), .conv_irq_r(irq));
	sar_analog_model u_sar_analog_model (.clk(clk), .sample_r(smp),
		.dac_code_r(code), .level(level), .comparator_in(cmp));
	task automatic tally_and_finish;
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		ta = 1;
		tw = 1;
		while (ta || tw) begin
			@(posedge clk);
			if (ta && awready === 1'b1) begin
				ta = 0;
				awvalid <= 1'b0;
			end
			if (tw && wready === 1'b1) begin
				tw = 0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		// Late ready makes the slave hold its response for a cycle
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
		resp = bresp;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		@(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		resp = rresp;
		`CHK(rdata, {24'h000000, e})
	endtask
	task automatic wait_irq(input int lim, input logic e);
		n = 0;
		// Always step once, so a flag left over from the last read is not taken
		do begin
			@(posedge clk);
			n++;
		end while (irq !== 1'b1 && n < lim);
		`CHK(irq, e)
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`OFF_STATUS_CONTROL_ONE, `SC1_RESET);
		rd(`OFF_CONFIG_REG, 8'h00);
		rd(8'h28, 8'h00);
		`CHK(resp, `RESP_SLVERR)
		wr(8'h28, 8'h55);
		`CHK(resp, `RESP_SLVERR)
		wr(`OFF_PIN_DISABLE_ONE, 8'hA5);
		wr(`OFF_PIN_DISABLE_THREE, 8'h0F);
		pins <= 24'hFFFFFF;
		repeat (3) @(posedge clk);
		`CHK(pin_analog, 24'h0F00A5)
		`CHK(port_read, 24'hF0FF5A)
		foreach (cfgs[i]) begin
			wr(`OFF_CONFIG_REG, cfgs[i]);
			wr(`OFF_STATUS_CONTROL_ONE, 8'h41);
			`CHK(osc_en, cfgs[i][1:0] == `SRC_ASYNC)
			`CHK(lowp, cfgs[i][7])
			wait_irq(lims[i], 1'b1);
			`CHK(chan, 5'h01)
			rd(`OFF_RESULT_HIGH, 8'h01);
			rd(`OFF_RESULT_LOW, 8'h52);
			repeat (2) @(posedge clk);
			`CHK(irq, 1'b0)
		end
		wr(`OFF_CONFIG_REG, 8'h68);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h41);
		repeat (100) @(posedge clk);
		wr(`OFF_CONFIG_REG, 8'h68);
		wait_irq(400, 1'b0);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h41);
		repeat (100) @(posedge clk);
		stop <= 1'b1;
		wait_irq(400, 1'b0);
		stop <= 1'b0;
		rd(`OFF_RESULT_LOW, 8'h52);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h5F);
		wait_irq(300, 1'b0);
		wr(`OFF_CONFIG_REG, 8'h2B);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h41);
		repeat (100) @(posedge clk);
		stop <= 1'b1;
		wait_irq(255, 1'b1);
		stop <= 1'b0;
		rd(`OFF_RESULT_LOW, 8'h52);
		wr(`OFF_CONFIG_REG, 8'h68);
		rd(`OFF_RESULT_HIGH, 8'h01);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h41);
		wait_irq(400, 1'b0);
		rd(`OFF_RESULT_LOW, 8'h52);
		wait_irq(165, 1'b1);
		rd(`OFF_RESULT_HIGH, 8'h01);
		rd(`OFF_RESULT_LOW, 8'h52);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h61);
		wait_irq(189, 1'b1);
		repeat (2) begin
			rd(`OFF_RESULT_LOW, 8'h52);
			wait_irq(160, 1'b1);
		end
		wr(`OFF_STATUS_CONTROL_ONE, 8'h5F);
		wr(`OFF_COMPARE_VALUE_HIGH, 8'h01);
		wr(`OFF_COMPARE_VALUE_LOW, 8'h00);
		wr(`OFF_STATUS_CONTROL_TWO, 8'h30);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h41);
		wait_irq(189, 1'b1);
		rd(`OFF_RESULT_HIGH, 8'h00);
		rd(`OFF_RESULT_LOW, 8'h52);
		wr(`OFF_STATUS_CONTROL_TWO, 8'h20);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h41);
		wait_irq(300, 1'b0);
		wr(`OFF_STATUS_CONTROL_TWO, 8'h40);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h41);
		wait_irq(300, 1'b0);
		hw_trig <= 1'b1;
		repeat (4) @(posedge clk);
		hw_trig <= 1'b0;
		repeat (60) @(posedge clk);
		hw_trig <= 1'b1;
		wait_irq(130, 1'b1);
		rd(`OFF_RESULT_LOW, 8'h52);
		wait_irq(300, 1'b0);
		level <= 11'h0A5;
		wr(`OFF_STATUS_CONTROL_TWO, 8'h00);
		wr(`OFF_CONFIG_REG, 8'h60);
		wr(`OFF_STATUS_CONTROL_ONE, 8'h41);
		wait_irq(165, 1'b1);
		rd(`OFF_RESULT_HIGH, 8'h00);
		rd(`OFF_RESULT_LOW, 8'h53);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`OFF_RESULT_HIGH, 8'h00);
		rd(`OFF_RESULT_LOW, 8'h00);
		rd(`OFF_STATUS_CONTROL_ONE, `SC1_RESET);
		`CHK(chan, `CHANNEL_OFF)
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ### verilog/sar_conversion_control.v
// Control of a successive approximation converter behind an AXI4-Lite
// register slave: clock choice, triggers, sequencing, result transfer.
// Assumes the analog core answers comparator_in for dac_code_r and that
// alternate, async and trigger inputs come from outside this clock domain.
//
// Functional notes
// RQ1 - Disabled in reset or channel all ones; idle after completion.
// RQ2 - Approximation yields 11 raw bits in 10-bit, 9 in 8-bit mode.
// RQ3 - Round to 10 bits over both results, or 8 bits into low only.
// RQ4 - Done flag set after result written; interrupt when enabled.
// RQ5 - Four clock sources selectable, bus clock after reset.
// RQ6 - Source divided by 1, 2, 4 or 8 to form conversion clock.
// RQ7 - Internal async clock keeps running in wait and stop.
// RQ8 - Pin disable forces high impedance, no pullup, port reads zero.
// RQ9 - Hardware trigger rising edge starts conversion when selected.
// RQ10 - Trigger edges during conversion or continuous run are ignored.
// RQ11 - Software trigger: control one write with live channel starts.
// RQ12 - Continuous mode restarts after each transfer until aborted.
// RQ13 - Result high read in 10-bit mode blocks transfer until low read.
// RQ14 - Blocked transfer restarts, except failed compare single stops.
// RQ15 - Software avoids reading results during a single conversion.
// RQ16 - Register writes, reset or stop without async clock abort.
// RQ17 - Abort keeps last results; reset clears them.
// RQ18 - Idle until start; async generator enabled only at start.
// RQ19 - Sample short or long, isolate, approximate, then transfer.
// RQ20 - First conversion within 20/23/40/43 conversion clocks plus 5 bus.
// RQ21 - Async source adds up to 5 us startup before first conversion.
// RQ22 - Later continuous conversions within 17/20/37/40 conversion clocks.
// RQ23 - Mode 00 is 8-bit, mode 10 is 10-bit.
// RQ24 - Compare passes on greater-or-equal or below; else no transfer.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`include "sar_ctl_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module sar_conversion_control #(
	parameter STARTUP_CYC = `ASYNC_STARTUP_NS / `CLK_PERIOD_NS,
	parameter PINS = 24
) (
	input wire clk,
	input wire sys_rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire alternate_clock,
	input wire internal_async_clock,
	input wire hw_trigger_input,
	input wire comparator_in,
	input wire stop_mode,
	input wire [PINS-1:0] port_pin_in,
	output reg [PINS-1:0] port_read_r,
	output reg [PINS-1:0] pin_analog_r,
	output reg async_osc_enable_r,
	output reg sample_r,
	output reg [4:0] channel_r,
	output reg [10:0] dac_code_r,
	output reg low_power_r,
	output reg conv_irq_r
);

	localparam ST_IDLE = 3'd0;
	localparam ST_WARM = 3'd1;
	localparam ST_SETUP = 3'd2;
	localparam ST_SAMPLE = 3'd3;
	localparam ST_SAR = 3'd4;
	localparam ST_FIN = 3'd5;
	localparam ST_XFER = 3'd6;

	// Configuration and result storage
	reg [7:0] sc1_r;
	reg [7:0] sc2_r;
	reg [7:0] cfg_r;
	reg [7:0] cvh_r;
	reg [7:0] cvl_r;
	reg [7:0] res_hi_r;
	reg [7:0] res_lo_r;
	reg [PINS-1:0] pin_dis_r;
	reg lock_r;

	wire irq_en = sc1_r[`SC1_IRQ_EN_BIT];
	wire cont_en = sc1_r[`SC1_CONT_BIT];
	wire [4:0] chan = sc1_r[4:0];
	wire hw_trg = sc2_r[`SC2_HWTRG_BIT];
	wire cmp_en = sc2_r[`SC2_CMP_EN_BIT];
	wire cmp_gt = sc2_r[`SC2_CMP_GT_BIT];
	wire [1:0] div_sel = cfg_r[6:5];
	wire long_smp = cfg_r[`CFG_LSMP_BIT];
	wire mode10 = (cfg_r[3:2] == `MODE_10BIT); // [RQ23]
	wire [1:0] src_sel = cfg_r[1:0];

	// Three-stage synchronisers; a level is taken once stages 2 and 3 agree
	wire [3:0] raw_in = {comparator_in, hw_trigger_input,
		internal_async_clock, alternate_clock};
	reg [3:0] sy1_r;
	reg [3:0] sy2_r;
	reg [3:0] sy3_r;
	reg [3:0] filt_r;
	wire [3:0] rise;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_sync
			always @(posedge clk) begin
				if (sys_rst) begin
					sy1_r[g] <= 1'b0;
					sy2_r[g] <= 1'b0;
					sy3_r[g] <= 1'b0;
					filt_r[g] <= 1'b0;
				end else begin
					sy1_r[g] <= raw_in[g];
					sy2_r[g] <= sy1_r[g];
					sy3_r[g] <= sy2_r[g];
					if (sy2_r[g] == sy3_r[g])
						filt_r[g] <= sy3_r[g];
				end
			end
			assign rise[g] = sy2_r[g] & sy3_r[g] & ~filt_r[g];
		end
	endgenerate
	wire cmp_bit = filt_r[3];

	// Conversion clock as a tick; alternate and async sources are
	// sampled, so they must stay well below half the bus rate.
	reg half_r;
	reg [2:0] div_cnt_r;
	reg src_tick;
	always @* begin
		case (src_sel) // [RQ5]
			`SRC_BUS: src_tick = 1'b1;
			`SRC_BUS_HALF: src_tick = half_r;
			`SRC_ALT: src_tick = rise[0];
			default: src_tick = rise[1];
		endcase
	end
	wire [2:0] div_max = (3'd1 << div_sel) - 3'd1;
	wire conversion_clock_tick = src_tick & (div_cnt_r == div_max); // [RQ6]

	// Bus write and read strobes
	reg aw_got_r;
	reg w_got_r;
	reg [7:0] wa_r;
	reg [7:0] wd_r;
	reg wlane_r;
	wire wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;
	wire wr_en = wr_go & wlane_r;
	wire wr_sc1 = wr_en & (wa_r == `OFF_STATUS_CONTROL_ONE);
	wire wr_sc2 = wr_en & (wa_r == `OFF_STATUS_CONTROL_TWO);
	wire wr_cfg = wr_en & (wa_r == `OFF_CONFIG_REG);
	wire wr_cvh = wr_en & (wa_r == `OFF_COMPARE_VALUE_HIGH);
	wire wr_cvl = wr_en & (wa_r == `OFF_COMPARE_VALUE_LOW);
	wire rd_go = s_axi_arvalid & s_axi_arready;
	wire rd_hi = rd_go & (s_axi_araddr == `OFF_RESULT_HIGH);
	wire rd_lo = rd_go & (s_axi_araddr == `OFF_RESULT_LOW);

	// Sequencer
	reg [2:0] state_r;
	reg [6:0] ph_cnt_r;
	reg [3:0] bit_r;
	reg [10:0] sar_r;
	reg first_r;
	wire busy = (state_r != ST_IDLE);
	wire trig_edge = rise[2] & hw_trg & ~busy
		& (chan != `CHANNEL_OFF); // [RQ10]
	wire sw_start = wr_sc1 & ~hw_trg & (wd_r[4:0] != `CHANNEL_OFF);
	wire stop_abort = stop_mode & (src_sel != `SRC_ASYNC); // [RQ7]
	wire abort = wr_sc1 | wr_sc2 | wr_cfg | wr_cvh | wr_cvl | stop_abort;

	// Rounding and compare at transfer time
	wire [10:0] rnd_sum = mode10 ? ({1'b0, sar_r[10:1]} + {10'h000, sar_r[0]})
		: ({3'h0, sar_r[8:1]} + {10'h000, sar_r[0]});
	wire [9:0] rounded = mode10
		? (rnd_sum[10] ? 10'h3FF : rnd_sum[9:0])
		: (rnd_sum[8] ? 10'h0FF : rnd_sum[9:0]); // [RQ3]
	wire [9:0] cmp_val = mode10 ? {cvh_r[1:0], cvl_r} : {2'h0, cvl_r};
	wire [10:0] diff = {1'b0, rounded} - {1'b0, cmp_val};
	wire ge = ~diff[10];
	wire cmp_pass = ~cmp_en | (cmp_gt ? ge : ~ge); // [RQ24]
	wire [9:0] xfer_val = cmp_en ? diff[9:0] : rounded;
	wire blocked = lock_r & mode10;
	wire in_xfer = (state_r == ST_XFER);
	wire do_xfer = in_xfer & ~blocked & cmp_pass;

	always @(posedge clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE; // [RQ1]
			ph_cnt_r <= 7'd0;
			bit_r <= 4'd0;
			sar_r <= 11'h000;
			first_r <= 1'b1;
			half_r <= 1'b0;
			div_cnt_r <= 3'd0;
			async_osc_enable_r <= 1'b0;
			sample_r <= 1'b0;
			dac_code_r <= 11'h000;
		end else begin
			half_r <= ~half_r;
			if (src_tick)
				div_cnt_r <= (div_cnt_r == div_max) ? 3'd0 : div_cnt_r + 3'd1;
			sample_r <= (state_r == ST_SAMPLE); // [RQ19]
			dac_code_r <= sar_r | (11'h001 << bit_r);
			if (abort && !sw_start) begin
				state_r <= ST_IDLE; // [RQ16]
				async_osc_enable_r <= 1'b0;
			end else if (sw_start || trig_edge) begin // [RQ9] [RQ11] [RQ16]
				first_r <= 1'b1;
				ph_cnt_r <= 7'd0;
				// Generator only powered from the start of a conversion
				async_osc_enable_r <= (src_sel == `SRC_ASYNC); // [RQ18]
				state_r <= (src_sel == `SRC_ASYNC) ? ST_WARM : ST_SETUP; // [RQ21]
				div_cnt_r <= 3'd0;
			end else begin
				case (state_r)
					ST_WARM: begin
						// Startup budget is counted in bus clocks
						if (ph_cnt_r == STARTUP_CYC[6:0] - 7'd1) begin
							ph_cnt_r <= 7'd0;
							state_r <= ST_SETUP;
						end else begin
							ph_cnt_r <= ph_cnt_r + 7'd1;
						end
					end
					ST_SETUP: if (conversion_clock_tick) begin // [RQ20]
						if (ph_cnt_r == `SETUP_CONVERSION_CLOCK - 1) begin
							ph_cnt_r <= 7'd0;
							state_r <= ST_SAMPLE;
						end else begin
							ph_cnt_r <= ph_cnt_r + 7'd1;
						end
					end
					ST_SAMPLE: if (conversion_clock_tick) begin // [RQ19]
						if (ph_cnt_r == (long_smp ? `SAMPLE_LONG_CONVERSION_CLOCK
							: `SAMPLE_SHORT_CONVERSION_CLOCK) - 1) begin
							ph_cnt_r <= 7'd0;
							sar_r <= 11'h000;
							bit_r <= mode10 ? 4'd10 : 4'd8; // [RQ2]
							state_r <= ST_SAR;
						end else begin
							ph_cnt_r <= ph_cnt_r + 7'd1;
						end
					end
					ST_SAR: if (conversion_clock_tick) begin // [RQ2]
						sar_r[bit_r] <= cmp_bit;
						if (bit_r == 4'd0)
							state_r <= ST_FIN;
						else
							bit_r <= bit_r - 4'd1;
					end
					ST_FIN: if (conversion_clock_tick) begin
						if (ph_cnt_r == `FINISH_CONVERSION_CLOCK - 1) begin
							ph_cnt_r <= 7'd0;
							state_r <= ST_XFER;
						end else begin
							ph_cnt_r <= ph_cnt_r + 7'd1;
						end
					end
					ST_XFER: begin
						first_r <= 1'b0;
						if ((blocked && !(cmp_en && !cmp_pass && !cont_en))
							|| cont_en) begin
							state_r <= ST_SAMPLE; // [RQ12] [RQ14] [RQ22]
							div_cnt_r <= 3'd0;
						end else begin
							state_r <= ST_IDLE; // [RQ1] [RQ14]
							async_osc_enable_r <= 1'b0;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Register file; a transfer that coincides with a write still lands
	always @(posedge clk) begin
		if (sys_rst) begin
			sc1_r <= `SC1_RESET;
			sc2_r <= 8'h00;
			cfg_r <= 8'h00; // [RQ5]
			cvh_r <= 8'h00;
			cvl_r <= 8'h00;
			res_hi_r <= 8'h00; // [RQ17]
			res_lo_r <= 8'h00;
			pin_dis_r <= {PINS{1'b0}};
			lock_r <= 1'b0;
		end else begin
			if (wr_sc1)
				sc1_r[6:0] <= wd_r[6:0];
			if (wr_sc2)
				sc2_r[6:4] <= wd_r[6:4];
			if (wr_cfg)
				cfg_r <= wd_r;
			if (wr_cvh)
				cvh_r <= {6'h00, wd_r[1:0]};
			if (wr_cvl)
				cvl_r <= wd_r;
			if (wr_en && wa_r == `OFF_PIN_DISABLE_ONE)
				pin_dis_r[7:0] <= wd_r;
			if (wr_en && wa_r == `OFF_PIN_DISABLE_TWO)
				pin_dis_r[15:8] <= wd_r;
			if (wr_en && wa_r == `OFF_PIN_DISABLE_THREE)
				pin_dis_r[23:16] <= wd_r;
			sc2_r[`SC2_ACTIVE_BIT] <= busy;
			// Done clears on a control one write or low-result read; set wins
			if (do_xfer)
				sc1_r[`SC1_DONE_BIT] <= 1'b1; // [RQ4]
			else if (wr_sc1 || rd_lo)
				sc1_r[`SC1_DONE_BIT] <= 1'b0;
			if (do_xfer) begin // [RQ3] [RQ17]
				res_hi_r <= mode10 ? {6'h00, xfer_val[9:8]} : 8'h00;
				res_lo_r <= xfer_val[7:0];
			end
			if (rd_lo || !mode10)
				lock_r <= 1'b0;
			else if (rd_hi)
				lock_r <= 1'b1; // [RQ13]
		end
	end

	// Pin control and outputs
	always @(posedge clk) begin
		if (sys_rst) begin
			pin_analog_r <= {PINS{1'b0}};
			port_read_r <= {PINS{1'b0}};
			channel_r <= `CHANNEL_OFF;
			low_power_r <= 1'b0;
			conv_irq_r <= 1'b0;
		end else begin
			pin_analog_r <= pin_dis_r; // [RQ8]
			port_read_r <= port_pin_in & ~pin_dis_r; // [RQ8]
			channel_r <= chan;
			low_power_r <= cfg_r[`CFG_LOWPWR_BIT];
			conv_irq_r <= sc1_r[`SC1_DONE_BIT] & irq_en; // [RQ4]
		end
	end

	// AXI4-Lite write channel: address and data taken in either order
	always @(posedge clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			wa_r <= 8'h00;
			wd_r <= 8'h00;
			wlane_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				wa_r <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wd_r <= s_axi_wdata[7:0];
				wlane_r <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wa_r > `OFF_PIN_DISABLE_THREE)
					? `RESP_SLVERR : `RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel; reads of results drive the interlock
	always @(posedge clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				if (s_axi_araddr[7:2] == `OFF_STATUS_CONTROL_ONE >> 2)
					s_axi_rdata <= {24'h000000, sc1_r};
				else if (s_axi_araddr[7:2] == `OFF_STATUS_CONTROL_TWO >> 2)
					s_axi_rdata <= {24'h000000, sc2_r};
				else if (s_axi_araddr[7:2] == `OFF_RESULT_HIGH >> 2)
					s_axi_rdata <= {24'h000000, res_hi_r};
				else if (s_axi_araddr[7:2] == `OFF_RESULT_LOW >> 2)
					s_axi_rdata <= {24'h000000, res_lo_r};
				else if (s_axi_araddr[7:2] == `OFF_COMPARE_VALUE_HIGH >> 2)
					s_axi_rdata <= {24'h000000, cvh_r};
				else if (s_axi_araddr[7:2] == `OFF_COMPARE_VALUE_LOW >> 2)
					s_axi_rdata <= {24'h000000, cvl_r};
				else if (s_axi_araddr[7:2] == `OFF_CONFIG_REG >> 2)
					s_axi_rdata <= {24'h000000, cfg_r};
				else if (s_axi_araddr[7:2] == `OFF_PIN_DISABLE_ONE >> 2)
					s_axi_rdata <= {24'h000000, pin_dis_r[7:0]};
				else if (s_axi_araddr[7:2] == `OFF_PIN_DISABLE_TWO >> 2)
					s_axi_rdata <= {24'h000000, pin_dis_r[15:8]};
				else if (s_axi_araddr[7:2] == `OFF_PIN_DISABLE_THREE >> 2)
					s_axi_rdata <= {24'h000000, pin_dis_r[23:16]};
				else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire
